// [logic/txd_map.svh]
`ifndef TXD_MAP_SVH
`define TXD_MAP_SVH

// Register offsets
`define TXD_ADDR_TIMER_HI 5'h04
`define TXD_ADDR_TIMER_LO 5'h05
`define TXD_ADDR_PULSE 5'h06

// Reset values
`define TXD_TIMER_HI_RST 8'hC2
`define TXD_TIMER_LO_RST 8'h00
`define TXD_PULSE_RST 8'h00

// Field positions in the timer high byte
`define TXD_START_SEL_MSB 7
`define TXD_START_SEL_LSB 6
`define TXD_LEN_HI_MSB 5

// Clock and carrier rates
`define TXD_CLK_KHZ 16'h4E20
`define TXD_CARRIER_KHZ 16'h34F8
`define TXD_TIMER_DIV 4'h8

// Pulse step and preset times
`define TXD_PULSE_STEP_PS 73746
`define TXD_PRE_VIC_NS 9440
`define TXD_PRE_A106_NS 2360
`define TXD_PRE_A212_NS 1400
`define TXD_PRE_A424_NS 737
`define TXD_PRE_CODE(ns) (8'(((ns) * 1000 + `TXD_PULSE_STEP_PS / 2) / `TXD_PULSE_STEP_PS))

`endif

// [logic/txd_pkg.sv]
package txd_pkg;

    typedef enum logic [2:0] {
        TXD_PROTO_VICINITY = 3'h0,
        TXD_PROTO_A106 = 3'h1,
        TXD_PROTO_A212 = 3'h2,
        TXD_PROTO_A424 = 3'h3,
        TXD_PROTO_A848 = 3'h4,
        TXD_PROTO_OTHER = 3'h5
    } txd_proto_type;

    typedef enum logic [1:0] {
        TXD_START_TX_SOF_BEGIN = 2'h0,
        TXD_START_TX_SOF_END = 2'h1,
        TXD_START_RX_SOF_BEGIN = 2'h2,
        TXD_START_RX_SOF_END = 2'h3
    } txd_start_type;

    typedef enum logic [1:0] {
        TXD_IDLE = 2'b01,
        TXD_COUNT = 2'b10
    } txd_state_type;

    typedef struct packed {
        logic [15:0] acc;
        logic [3:0] div;
        logic carrier_tick;
        logic timer_tick;
    } txd_tick_reg_type;

    typedef struct packed {
        logic en_meta;
        logic en_sync;
        logic [7:0] timer_hi;
        logic [7:0] timer_lo;
        logic [7:0] pulse_len;
        txd_state_type tstate;
        logic [13:0] count;
        logic [7:0] pulse_cnt;
        logic tx_start;
        logic delay_busy;
        logic mod_pulse;
        logic [7:0] rdata;
    } txd_reg_type;

endpackage : txd_pkg

// [logic/txd_tick_gen.sv]
`include "txd_map.svh"

module txd_tick_gen
    import txd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic carrier_tick_o,
    output logic timer_tick_o
);

    txd_tick_reg_type q;
    txd_tick_reg_type next_q;
    logic [15:0] sum;

    // Phase accumulator: carrier periods in the 20 MHz domain
    always_comb begin
        next_q = q;
        next_q.carrier_tick = 1'b0;
        next_q.timer_tick = 1'b0;
        sum = q.acc + `TXD_CARRIER_KHZ;
        if (sum >= `TXD_CLK_KHZ) begin
            next_q.acc = sum - `TXD_CLK_KHZ;
            next_q.carrier_tick = 1'b1;
            if (q.div == `TXD_TIMER_DIV - 4'h1) begin
                next_q.div = 4'h0;
                next_q.timer_tick = 1'b1;
            end else begin
                next_q.div = q.div + 4'h1;
            end
        end else begin
            next_q.acc = sum;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign carrier_tick_o = q.carrier_tick;
    assign timer_tick_o = q.timer_tick;

    chk_timer_on_carrier: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        timer_tick_o |-> carrier_tick_o)
        else $error("timer tick without carrier tick");

    chk_timer_div_eight: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q.carrier_tick && q.div == 4'h0) |-> q.timer_tick)
        else $error("timer tick not every eighth carrier tick");

endmodule : txd_tick_gen

// [logic/txd_core.sv]
// Summary of operation
// - Start event chosen by timer-high bits 7:6
// - Fourteen-bit length, 590 ns per count
// - Transmit starts when length elapses after event
// - Zero length: timer off, no delay
// - Timer high defaults to 0xC2
// - Timer low defaults to zero
// - Zero pulse length keeps protocol pulse
// - Nonzero pulse length sets pulse in 73.7 ns
// - Pulse length clears on reset, disable, A848 or other protocol write
// - Protocol write presets pulse length per protocol
`include "txd_map.svh"

module txd_core
    import txd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [4:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic proto_wr_i,
    input wire logic [2:0] proto_i,
    input wire logic tx_sof_begin_i,
    input wire logic tx_sof_end_i,
    input wire logic rx_sof_begin_i,
    input wire logic rx_sof_end_i,
    input wire logic mod_req_i,
    input wire logic proto_mod_i,
    output logic [7:0] rdata_o,
    output logic tx_start_o,
    output logic delay_busy_o,
    output logic mod_pulse_o
);

    txd_reg_type q;
    txd_reg_type next_q;
    logic carrier_tick;
    logic timer_tick;
    logic start_evt;
    logic [13:0] length;
    logic [7:0] preset;

    txd_tick_gen u_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .carrier_tick_o(carrier_tick),
        .timer_tick_o(timer_tick)
    );

    assign length = {q.timer_hi[`TXD_LEN_HI_MSB:0], q.timer_lo};

    always_comb begin
        unique case (txd_start_type'(q.timer_hi[`TXD_START_SEL_MSB:`TXD_START_SEL_LSB]))
            TXD_START_TX_SOF_BEGIN: start_evt = tx_sof_begin_i;
            TXD_START_TX_SOF_END: start_evt = tx_sof_end_i;
            TXD_START_RX_SOF_BEGIN: start_evt = rx_sof_begin_i;
            TXD_START_RX_SOF_END: start_evt = rx_sof_end_i;
        endcase
    end

    always_comb begin
        case (txd_proto_type'(proto_i))
            TXD_PROTO_VICINITY: preset = `TXD_PRE_CODE(`TXD_PRE_VIC_NS);
            TXD_PROTO_A106: preset = `TXD_PRE_CODE(`TXD_PRE_A106_NS);
            TXD_PROTO_A212: preset = `TXD_PRE_CODE(`TXD_PRE_A212_NS);
            TXD_PROTO_A424: preset = `TXD_PRE_CODE(`TXD_PRE_A424_NS);
            default: preset = `TXD_PULSE_RST;
        endcase
    end

    always_comb begin
        next_q = q;
        next_q.en_meta = enable_i;
        next_q.en_sync = q.en_meta;
        next_q.tx_start = 1'b0;

        // Register file: defaults while disabled; timer defaults and pulse preset on protocol write
        if (!q.en_sync) begin
            next_q.timer_hi = `TXD_TIMER_HI_RST;
            next_q.timer_lo = `TXD_TIMER_LO_RST;
            next_q.pulse_len = `TXD_PULSE_RST;
        end else if (proto_wr_i) begin
            next_q.timer_hi = `TXD_TIMER_HI_RST;
            next_q.timer_lo = `TXD_TIMER_LO_RST;
            next_q.pulse_len = preset;
        end else if (wr_en_i) begin
            if (addr_i == `TXD_ADDR_TIMER_HI) begin
                next_q.timer_hi = wdata_i;
            end
            if (addr_i == `TXD_ADDR_TIMER_LO) begin
                next_q.timer_lo = wdata_i;
            end
            if (addr_i == `TXD_ADDR_PULSE) begin
                next_q.pulse_len = wdata_i;
            end
        end

        if (rd_en_i) begin
            if (addr_i == `TXD_ADDR_TIMER_HI) begin
                next_q.rdata = q.timer_hi;
            end else if (addr_i == `TXD_ADDR_TIMER_LO) begin
                next_q.rdata = q.timer_lo;
            end else if (addr_i == `TXD_ADDR_PULSE) begin
                next_q.rdata = q.pulse_len;
            end else begin
                next_q.rdata = 8'h00;
            end
        end

        // Delayed transmission timer
        if (!q.en_sync) begin
            next_q.tstate = TXD_IDLE;
            next_q.count = 14'h0000;
        end else begin
            unique case (q.tstate)
                TXD_IDLE: begin
                    if (start_evt) begin
                        if (length == 14'h0000) begin
                            next_q.tx_start = 1'b1;
                        end else begin
                            next_q.count = length;
                            next_q.tstate = TXD_COUNT;
                        end
                    end
                end
                TXD_COUNT: begin
                    if (timer_tick) begin
                        if (q.count == 14'h0001) begin
                            next_q.tx_start = 1'b1;
                            next_q.count = 14'h0000;
                            next_q.tstate = TXD_IDLE;
                        end else begin
                            next_q.count = q.count - 14'h0001;
                        end
                    end
                end
            endcase
        end
        next_q.delay_busy = (next_q.tstate == TXD_COUNT);

        // Modulation pulse length
        if (q.pulse_len == 8'h00) begin
            next_q.pulse_cnt = 8'h00;
            next_q.mod_pulse = proto_mod_i;
        end else begin
            if (mod_req_i && q.pulse_cnt == 8'h00) begin
                next_q.pulse_cnt = q.pulse_len;
            end else if (carrier_tick && q.pulse_cnt != 8'h00) begin
                next_q.pulse_cnt = q.pulse_cnt - 8'h01;
            end
            next_q.mod_pulse = (next_q.pulse_cnt != 8'h00);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{en_meta: 1'b0, en_sync: 1'b0, timer_hi: `TXD_TIMER_HI_RST,
                   timer_lo: `TXD_TIMER_LO_RST, pulse_len: `TXD_PULSE_RST,
                   tstate: TXD_IDLE, count: 14'h0000, pulse_cnt: 8'h00,
                   tx_start: 1'b0, delay_busy: 1'b0, mod_pulse: 1'b0, rdata: 8'h00};
        end else begin
            q <= next_q;
        end
    end

    assign rdata_o = q.rdata;
    assign tx_start_o = q.tx_start;
    assign delay_busy_o = q.delay_busy;
    assign mod_pulse_o = q.mod_pulse;

    sequence s_timer_armed;
        q.en_sync && q.tstate == TXD_IDLE && start_evt && length != 14'h0000;
    endsequence

    sequence s_timer_last;
        q.en_sync && q.tstate == TXD_COUNT && timer_tick && q.count == 14'h0001;
    endsequence

    chk_start_no_event: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q.tstate == TXD_IDLE && !start_evt) |=> !delay_busy_o && !tx_start_o)
        else $error("timer started without the selected event");

    chk_count_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_timer_armed |=> delay_busy_o && q.count == $past(length) && !tx_start_o)
        else $error("timer did not load the fourteen-bit length");

    chk_expiry_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_timer_last |=> tx_start_o && !delay_busy_o ##1 (!tx_start_o || $past(start_evt && length == 14'h0000)))
        else $error("no transmit start at expiry");

    chk_zero_no_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q.en_sync && q.tstate == TXD_IDLE && start_evt && length == 14'h0000) |=> tx_start_o && !delay_busy_o)
        else $error("zero length did not start at once");

    chk_high_default: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!q.en_sync || proto_wr_i) |=> q.timer_hi == `TXD_TIMER_HI_RST)
        else $error("timer high byte not defaulted");

    chk_low_default: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!q.en_sync || proto_wr_i) |=> q.timer_lo == `TXD_TIMER_LO_RST)
        else $error("timer low byte not defaulted");

    chk_pulse_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        q.pulse_len == 8'h00 |=> mod_pulse_o == $past(proto_mod_i))
        else $error("protocol pulse not passed through");

    chk_pulse_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q.pulse_len != 8'h00 && mod_req_i && q.pulse_cnt == 8'h00)
        |=> mod_pulse_o && q.pulse_cnt == $past(q.pulse_len))
        else $error("override pulse not started with its length");

    chk_pulse_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!q.en_sync || (proto_wr_i && proto_i == TXD_PROTO_A848)) |=> q.pulse_len == 8'h00)
        else $error("pulse length not cleared");

    chk_pulse_preset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (q.en_sync && proto_wr_i && proto_i == TXD_PROTO_A106) |=> q.pulse_len == 8'h20)
        else $error("pulse preset wrong for 106 kbps");

    chk_stop_after: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_timer_last ##1 (!start_evt) |=> !delay_busy_o)
        else $error("timer kept running after expiry");

endmodule : txd_core

// [dv/txd_tag_model.sv]
module txd_tag_model
    import txd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mod_pulse_i,
    output logic [15:0] width_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] run;
    // Tag senses field gaps; keeps width of last gap in clocks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run <= 16'h0000;
            width_o <= 16'h0000;
        end else if (mod_pulse_i) begin
            run <= run + 16'h0001;
        end else begin
            if (run != 16'h0000) width_o <= run;
            run <= 16'h0000;
        end
    end
endmodule : txd_tag_model

// [dv/tb.sv]
module tb
    import txd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic enable_i = 1'b1;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [4:0] addr_i = 5'h00;
    logic [7:0] wdata_i = 8'h00;
    logic proto_wr_i = 1'b0;
    logic [2:0] proto_i = 3'h0;
    logic [3:0] ev = 4'h0;
    logic mod_req_i = 1'b0;
    logic proto_mod_i = 1'b0;
    logic [7:0] rdata_o;
    logic tx_start_o;
    logic delay_busy_o;
    logic mod_pulse_o;
    logic [15:0] width;
    int failures = 0;
    int checks = 0;
    always #25 clk_i = ~clk_i;
    txd_core txd_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable_i), .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .proto_wr_i(proto_wr_i), .proto_i(proto_i),
        .tx_sof_begin_i(ev[0]), .tx_sof_end_i(ev[1]), .rx_sof_begin_i(ev[2]), .rx_sof_end_i(ev[3]),
        .mod_req_i(mod_req_i), .proto_mod_i(proto_mod_i), .rdata_o(rdata_o), .tx_start_o(tx_start_o),
        .delay_busy_o(delay_busy_o), .mod_pulse_o(mod_pulse_o));
    txd_tag_model txd_tag_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .mod_pulse_i(mod_pulse_o), .width_o(width));
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    task automatic step();
        @(posedge clk_i);
        #1;
    endtask : step
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask : cmp1
    task automatic cmp_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : cmp_rng
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        step();
        addr_i = a;
        wdata_i = d;
        wr_en_i = 1'b1;
        step();
        wr_en_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        step();
        addr_i = a;
        rd_en_i = 1'b1;
        step();
        rd_en_i = 1'b0;
        cmp8(rdata_o, exp);
    endtask : rd
    task automatic proto(input logic [2:0] p);
        step();
        proto_i = p;
        proto_wr_i = 1'b1;
        step();
        proto_wr_i = 1'b0;
    endtask : proto
    task automatic fire(input int sel, output int n, output logic busy1);
        step();
        ev = 4'h1 << sel;
        n = 0;
        busy1 = 1'b0;
        while (n < 4000 && tx_start_o !== 1'b1) begin
            step();
            ev = 4'h0;
            n++;
            if (n == 1) busy1 = delay_busy_o;
        end
    endtask : fire
    task automatic t_defaults();
        rd(5'h04, 8'hC2);
        rd(5'h05, 8'h00);
        rd(5'h06, 8'h00);
        rd(5'h07, 8'h00);
        wr(5'h04, 8'h3F);
        rd(5'h04, 8'h3F);
    endtask : t_defaults
    task automatic t_proto();
        logic [7:0] pre [6] = '{8'h80, 8'h20, 8'h13, 8'h0A, 8'h00, 8'h00};
        for (int p = 0; p < 6; p++) begin
            wr(5'h04, 8'h11);
            wr(5'h05, 8'hAA);
            wr(5'h06, 8'hFF);
            proto(3'(p));
            rd(5'h06, pre[p]);
            rd(5'h04, 8'hC2);
            rd(5'h05, 8'h00);
        end
    endtask : t_proto
    task automatic t_enable();
        wr(5'h04, 8'h01);
        wr(5'h05, 8'h01);
        wr(5'h06, 8'h01);
        enable_i = 1'b0;
        repeat (4) step();
        enable_i = 1'b1;
        repeat (4) step();
        rd(5'h04, 8'hC2);
        rd(5'h05, 8'h00);
        rd(5'h06, 8'h00);
    endtask : t_enable
    task automatic t_timer();
        int n;
        int seen;
        logic b;
        wr(5'h04, 8'h00);
        fire(0, n, b);
        cmp_rng(n, 1, 1);
        for (int s = 0; s < 4; s++) begin
            // Length 258 uses both bytes
            wr(5'h04, {2'(s), 6'h01});
            wr(5'h05, 8'h02);
            step();
            ev = 4'h1 << ((s + 1) % 4);
            step();
            ev = 4'h0;
            repeat (3) step();
            cmp1(delay_busy_o, 1'b0);
            fire(s, n, b);
            cmp1(b, 1'b1);
            cmp_rng(n, 257 * 160000 / 13560, 258 * 160000 / 13560 + 3);
            cmp1(delay_busy_o, 1'b0);
            seen = 0;
            repeat (40) begin
                step();
                if (tx_start_o !== 1'b0 || delay_busy_o !== 1'b0) seen++;
            end
            cmp_rng(seen, 0, 0);
        end
    endtask : t_timer
    task automatic t_pulse();
        proto(3'h4);
        proto_mod_i = 1'b1;
        step();
        cmp1(mod_pulse_o, 1'b1);
        proto_mod_i = 1'b0;
        step();
        cmp1(mod_pulse_o, 1'b0);
        wr(5'h06, 8'h14);
        step();
        mod_req_i = 1'b1;
        step();
        mod_req_i = 1'b0;
        cmp1(mod_pulse_o, 1'b1);
        repeat (60) step();
        cmp_rng(int'(width), 20 * 20000 / 13560 - 2, 20 * 20000 / 13560 + 2);
    endtask : t_pulse
    initial begin
        repeat (8) step();
        rst_n_i = 1'b1;
        repeat (4) step();
        t_defaults();
        t_proto();
        t_enable();
        t_timer();
        t_pulse();
        complete_run();
    end
    initial begin
        #2000000;
        failures++;
        complete_run();
    end
endmodule : tb
